// file: pkg/adcmp_params.svh
// offsets, field positions, reset values of the digital comparator
`ifndef ADCMP_PARAMS_SVH
`define ADCMP_PARAMS_SVH
// register byte offsets
`define ADCMP_OFS_CTRL 8'h00
`define ADCMP_OFS_ENL 8'h04
`define ADCMP_OFS_ENH 8'h08
`define ADCMP_OFS_THLO 8'h0C
`define ADCMP_OFS_THHI 8'h10
`define ADCMP_OFS_ISTS 8'h14
`define ADCMP_OFS_ICLR 8'h18
`define ADCMP_OFS_IEN 8'h1C
// control field positions
`define ADCMP_CTRL_CHAN_LSB 8
`define ADCMP_CTRL_ON_BIT 7
`define ADCMP_CTRL_IRQEN_BIT 6
`define ADCMP_CTRL_STAT_BIT 5
`define ADCMP_CTRL_BETWEEN_BIT 4
`define ADCMP_CTRL_ABOVE_HI_BIT 3
`define ADCMP_CTRL_BELOW_HI_BIT 2
`define ADCMP_CTRL_ABOVE_LO_BIT 1
`define ADCMP_CTRL_BELOW_LO_BIT 0
// implemented bits
`define ADCMP_CTRL_WMASK 16'h00DF
`define ADCMP_ENH_MASK 16'h003F
`define ADCMP_NUM_CHAN 5'h16
// reset values
`define ADCMP_RST_REG16 16'h0000
`define ADCMP_RST_CHAN 5'h00
`define ADCMP_RST_IRQ 1'h0
`endif

// file: pkg/adcmp_pkg.sv
// types shared by the digital comparator files
package adcmp_pkg;
   // one finished conversion from the result producer
   typedef struct packed {
      logic valid;
      logic [4:0] chan;
      logic [15:0] data;
   } adcmp_result_t;

   // one register write taken from the bus
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
   } adcmp_regwr_t;

   // one register read taken from the bus
   typedef struct packed {
      logic en;
      logic [7:0] addr;
   } adcmp_regrd_t;
endpackage

// file: src/adcmp_axil_slave.sv
// axi4-lite slave front end for the comparator registers
`timescale 1ns/1ns
module adcmp_axil_slave (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   output adcmp_pkg::adcmp_regwr_t wr,
   input wire logic wr_err,
   output adcmp_pkg::adcmp_regrd_t rd,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // address and data may arrive in either order; hold each once taken
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign wr.en = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr.addr = awaddr_q;
   assign wr.data = wdata_q;
   assign wr.strb = wstrb_q;

   // capture of write address and data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr.en) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr.en) begin
            w_have_q <= 1'b0;
         end
      end
   end

   // write response, slverr on an unmapped offset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (wr.en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? 2'h2 : 2'h0;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // reads answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   assign rd.en = s_axi_arvalid && s_axi_arready;
   assign rd.addr = s_axi_araddr;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (rd.en) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// file: src/adcmp_top.sv
// digital comparator on the adc result path, with register file
//
// Summary of operation
// - low enable register gates channels 0 to 15
// - high enable bits 5..0 gate channels 16-21
// - compare only results of enabled channels
// - high enable bits 15..6 read zero
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "adcmp_params.svh"
module adcmp_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // conversion results
   input adcmp_pkg::adcmp_result_t result,
   // event and interrupt
   output logic cmp_event,
   output logic irq
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
         input logic [31:0] wdata, input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) res[7:0] = wdata[7:0];
      if (strb[1]) res[15:8] = wdata[15:8];
      return res;
   endfunction

   // whether a register offset is mapped
   function automatic logic mapped(input logic [7:0] a);
      return a == `ADCMP_OFS_CTRL || a == `ADCMP_OFS_ENL ||
         a == `ADCMP_OFS_ENH || a == `ADCMP_OFS_THLO ||
         a == `ADCMP_OFS_THHI || a == `ADCMP_OFS_ISTS ||
         a == `ADCMP_OFS_ICLR || a == `ADCMP_OFS_IEN;
   endfunction

   // ------------------------------------------------------------
   // bus front end
   // ------------------------------------------------------------
   adcmp_pkg::adcmp_regwr_t wr;
   adcmp_pkg::adcmp_regrd_t rd;
   logic [31:0] rd_data;

   adcmp_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr(wr),
      .wr_err(!mapped(wr.addr)),
      .rd(rd),
      .rd_data(rd_data),
      .rd_err(!mapped(rd.addr))
   );

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [15:0] enl_q;
   logic [15:0] enh_q;
   logic [15:0] thlo_q;
   logic [15:0] thhi_q;
   logic [4:0] chan_q;
   logic stat_q;
   logic ists_q;
   logic iena_q;
   logic event_q;

   logic wr_ctrl;
   logic rd_ctrl;
   logic unit_on;
   logic [21:0] gate_vec;
   logic gate;
   logic hit;
   logic ev_d;

   assign wr_ctrl = wr.en && wr.addr == `ADCMP_OFS_CTRL;
   assign rd_ctrl = rd.en && rd.addr == `ADCMP_OFS_CTRL;
   assign unit_on = ctrl_q[`ADCMP_CTRL_ON_BIT];

   // writable control bits; index and status bits stay hardware-owned
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `ADCMP_RST_REG16;
      end else if (wr_ctrl) begin
         ctrl_q <= merge16(ctrl_q, wr.data, wr.strb) & `ADCMP_CTRL_WMASK;
      end
   end

   // channel gates and thresholds
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enl_q <= `ADCMP_RST_REG16;
         enh_q <= `ADCMP_RST_REG16;
         thlo_q <= `ADCMP_RST_REG16;
         thhi_q <= `ADCMP_RST_REG16;
      end else if (wr.en) begin
         if (wr.addr == `ADCMP_OFS_ENL)
            enl_q <= merge16(enl_q, wr.data, wr.strb);
         if (wr.addr == `ADCMP_OFS_ENH)
            enh_q <= merge16(enh_q, wr.data, wr.strb)
               & `ADCMP_ENH_MASK;
         if (wr.addr == `ADCMP_OFS_THLO)
            thlo_q <= merge16(thlo_q, wr.data, wr.strb);
         if (wr.addr == `ADCMP_OFS_THHI)
            thhi_q <= merge16(thhi_q, wr.data, wr.strb);
      end
   end

   // ------------------------------------------------------------
   // comparison
   // ------------------------------------------------------------

   // channels 22..31 are reserved and never gated in
   assign gate_vec = {enh_q[5:0], enl_q};
   assign gate = result.chan < `ADCMP_NUM_CHAN
      && gate_vec[result.chan];

   // any selected condition counts; unsigned compare of raw results
   always_comb begin
      hit = 1'b0;
      if (ctrl_q[`ADCMP_CTRL_BELOW_LO_BIT] && result.data < thlo_q)
         hit = 1'b1;
      if (ctrl_q[`ADCMP_CTRL_ABOVE_LO_BIT] && result.data >= thlo_q)
         hit = 1'b1;
      if (ctrl_q[`ADCMP_CTRL_BELOW_HI_BIT] && result.data < thhi_q)
         hit = 1'b1;
      if (ctrl_q[`ADCMP_CTRL_ABOVE_HI_BIT] && result.data >= thhi_q)
         hit = 1'b1;
      if (ctrl_q[`ADCMP_CTRL_BETWEEN_BIT] && result.data >= thlo_q
            && result.data < thhi_q)
         hit = 1'b1;
   end

   assign ev_d = result.valid && unit_on && gate && hit;

   // event pulse and the causing channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_q <= 1'b0;
         chan_q <= `ADCMP_RST_CHAN;
      end else begin
         event_q <= ev_d;
         if (ev_d)
            chan_q <= result.chan;
      end
   end

   // status clears on a read of the control word or when switched off;
   // a new event in the same cycle wins over the read clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_q <= 1'b0;
      end else if (ev_d) begin
         stat_q <= 1'b1;
      end else if (rd_ctrl || !unit_on) begin
         stat_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------

   // sticky status only catches events allowed onto the adc interrupt
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ists_q <= `ADCMP_RST_IRQ;
         iena_q <= `ADCMP_RST_IRQ;
      end else begin
         if (ev_d && ctrl_q[`ADCMP_CTRL_IRQEN_BIT])
            ists_q <= 1'b1;
         else if (wr.en && wr.addr == `ADCMP_OFS_ICLR && wr.strb[0]
               && wr.data[0])
            ists_q <= 1'b0;
         if (wr.en && wr.addr == `ADCMP_OFS_IEN && wr.strb[0])
            iena_q <= wr.data[0];
      end
   end

   // level interrupt and event pulse from flip-flops
   assign irq = ists_q && iena_q;
   assign cmp_event = event_q;

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   always_comb begin
      rd_data = 32'h00000000;
      unique case (rd.addr)
         `ADCMP_OFS_CTRL: begin
            rd_data[15:0] = ctrl_q;
            rd_data[`ADCMP_CTRL_CHAN_LSB +: 5] = chan_q;
            rd_data[`ADCMP_CTRL_STAT_BIT] = stat_q;
         end
         `ADCMP_OFS_ENL: rd_data[15:0] = enl_q;
         `ADCMP_OFS_ENH: rd_data[15:0] = enh_q & `ADCMP_ENH_MASK;
         `ADCMP_OFS_THLO: rd_data[15:0] = thlo_q;
         `ADCMP_OFS_THHI: rd_data[15:0] = thhi_q;
         `ADCMP_OFS_ISTS: rd_data[0] = ists_q;
         `ADCMP_OFS_IEN: rd_data[0] = iena_q;
         default: rd_data = 32'h00000000; // clear register reads zero
      endcase
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_result_in;
      result.valid && unit_on && hit;
   endsequence

   sequence seq_ctrl_read_later;
      ##1 s_axi_rvalid;
   endsequence

   a_low_gate_wr: assert property (
      wr.en && wr.addr == `ADCMP_OFS_ENL && wr.strb == 4'hF
      |=> enl_q == $past(wr.data[15:0]))
      else $error("low enable register did not take the write");

   a_high_gate_wr: assert property (
      wr.en && wr.addr == `ADCMP_OFS_ENH && wr.strb[0]
      |=> enh_q[5:0] == $past(wr.data[5:0]))
      else $error("high enable bits did not take the write");

   a_gated_out_quiet: assert property (
      result.valid && !gate |=> !event_q)
      else $error("event from a channel that is not enabled");

   a_high_upper_zero: assert property (
      rd.en && rd.addr == `ADCMP_OFS_ENH
      |-> seq_ctrl_read_later ##0 s_axi_rdata[15:6] == 10'h000)
      else $error("unimplemented high enable bits read nonzero");

   a_chan_loaded: assert property (
      event_q |-> chan_q == $past(result.chan) && chan_q < 5'h16)
      else $error("event channel index wrong");

   a_event_raised: assert property (
      seq_result_in ##0 gate |=> event_q && stat_q)
      else $error("selected condition gave no event");

   a_irq_follows: assert property (
      seq_result_in ##0 gate && ctrl_q[`ADCMP_CTRL_IRQEN_BIT] && iena_q
      && !(wr.en && wr.addr == `ADCMP_OFS_IEN)
      |=> irq ##1 (irq || $past(wr.en)))
      else $error("enabled event did not hold the interrupt");
endmodule

// file: testbench/adcmp_result_src.sv
// conversion result producer model feeding the comparator
`timescale 1ns/1ns
module adcmp_result_src (
   // clock
   input wire logic aclk,
   // result stream
   output adcmp_pkg::adcmp_result_t result
);
   // ------------------
   // result driver
   // ------------------
   // idle payload is the inverse of the last one so nothing leans on it
   initial begin
      result = '0;
   end

   // one result per call, qualified for exactly one edge
   task automatic send(input logic [4:0] c, input logic [15:0] d);
      result <= '{valid: 1'b1, chan: c, data: d};
      @(posedge aclk);
      result <= '{valid: 1'b0, chan: ~c, data: ~d};
   endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the digital comparator
`timescale 1ns/1ns
`include "adcmp_params.svh"
module testbench;
   // ------------------
   // signals
   // ------------------
   logic aclk, aresetn;
   logic [7:0] awaddr, araddr;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, rdat;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, rrsp, wrsp;
   adcmp_pkg::adcmp_result_t result;
   logic cmp_event, irq, e;
   logic [4:0] last_ch;
   logic [15:0] lo_thr = 16'h0100;
   logic [15:0] hi_thr = 16'h0200;
   logic [15:0] dv [4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;

   // 4 ns clock; bus defaults at time zero, responses always accepted
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      aresetn <= 1'b0;
      awaddr <= 8'h00;
      araddr <= 8'h00;
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      arvalid <= 1'b0;
      wdata <= 32'h0;
      wstrb <= 4'hF;
      bready <= 1'b1;
      rready <= 1'b1;
   end

   adcmp_top i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .result(result),
      .cmp_event(cmp_event), .irq(irq)
   );
   adcmp_result_src i_src (.aclk(aclk), .result(result));

   // ------------------
   // tasks
   // ------------------
   task automatic end_sim();
      $display("checks=%0d miscompares=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ready is sampled at the falling edge, where it is settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic pa, pw, ta, tw, b;
      pa = 1'b1;
      pw = 1'b1;
      b = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (pa || pw || !b) begin
         @(negedge aclk);
         ta = pa && awready;
         tw = pw && wready;
         b = bvalid;
         wrsp = bresp;
         @(posedge aclk);
         if (ta) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (tw) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
   endtask

   task automatic rd(input logic [7:0] a);
      logic pa, ta, got;
      pa = 1'b1;
      got = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!got) begin
         @(negedge aclk);
         ta = pa && arready;
         got = !pa && rvalid;
         rdat = rdata;
         rrsp = rresp;
         @(posedge aclk);
         if (ta) begin
            pa = 1'b0;
            arvalid <= 1'b0;
         end
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] x);
      rd(a);
      chk(rdat, x);
   endtask

   // one result, then the pulse is looked at in the cycle after
   task automatic ev(input logic [4:0] c, input logic [15:0] d,
                     input logic x);
      i_src.send(c, d);
      #1;
      chk(32'(cmp_event), 32'(x));
      @(posedge aclk);
   endtask

   task automatic irqchk(input logic x);
      #1;
      chk(32'(irq), 32'(x));
      @(posedge aclk);
   endtask

   // select bits: 0 below low .. 4 between, unsigned
   function automatic logic hit(input int k, input logic [15:0] d);
      logic [4:0] s;
      s = {lo_thr <= d && d < hi_thr, d >= hi_thr, d < hi_thr,
           d >= lo_thr, d < lo_thr};
      return s[k];
   endfunction

   // ------------------
   // tests
   // ------------------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         rchk(8'(4 * i), 32'h0);
      end
      rd(8'h20);
      chk(32'(rrsp), 32'h2);
      chk(rdat, 32'h0);
      $display("test reset_map done");
      wr(`ADCMP_OFS_ENL, 32'hFFFF_FFFF);
      rchk(`ADCMP_OFS_ENL, 32'h0000_FFFF);
      wr(`ADCMP_OFS_ENH, 32'hFFFF_FFFF);
      rchk(`ADCMP_OFS_ENH, 32'h0000_003F);
      wr(`ADCMP_OFS_CTRL, 32'h0000_FFFF);
      rchk(`ADCMP_OFS_CTRL, 32'h0000_00DF);
      wr(`ADCMP_OFS_THLO, 32'(lo_thr));
      wr(`ADCMP_OFS_THHI, 32'(hi_thr));
      wr(`ADCMP_OFS_IEN, 32'h1);
      $display("test enables done");
      last_ch = 5'h00;
      for (int k = 0; k < 5; k++) begin
         wr(`ADCMP_OFS_CTRL, 32'h0000_00C0 | (32'h1 << k));
         for (int j = 0; j < 4; j++) begin
            e = hit(k, dv[j]);
            ev(5'(4 * k + j), dv[j], e);
            last_ch = e ? 5'(4 * k + j) : last_ch;
            rchk(`ADCMP_OFS_CTRL,
                 {19'h0, last_ch, 2'b11, e, 5'(1 << k)});
         end
      end
      irqchk(1'b1);
      rchk(`ADCMP_OFS_ISTS, 32'h1);
      wr(`ADCMP_OFS_ICLR, 32'h1);
      rchk(`ADCMP_OFS_ISTS, 32'h0);
      irqchk(1'b0);
      $display("test conditions done");
      wr(`ADCMP_OFS_ENL, 32'h0000_FFF7);
      wr(`ADCMP_OFS_ENH, 32'h0000_0020);
      wr(`ADCMP_OFS_CTRL, 32'h0000_00C1);
      ev(5'd3, 16'h0, 1'b0);
      ev(5'd0, 16'h0, 1'b1);
      ev(5'd21, 16'h0, 1'b1);
      rchk(`ADCMP_OFS_CTRL, {19'h0, 5'd21, 3'b111, 5'h01});
      ev(5'd20, 16'h0, 1'b0);
      ev(5'd22, 16'h0, 1'b0);
      ev(5'd31, 16'h0, 1'b0);
      rchk(`ADCMP_OFS_CTRL, {19'h0, 5'd21, 3'b110, 5'h01});
      $display("test gating done");
      wr(`ADCMP_OFS_ICLR, 32'h1);
      wr(`ADCMP_OFS_IEN, 32'h0);
      ev(5'd0, 16'h0, 1'b1);
      irqchk(1'b0);
      rchk(`ADCMP_OFS_ISTS, 32'h1);
      wr(`ADCMP_OFS_IEN, 32'h1);
      irqchk(1'b1);
      wr(`ADCMP_OFS_ICLR, 32'h1);
      wr(`ADCMP_OFS_CTRL, 32'h0000_0081);
      ev(5'd0, 16'h0, 1'b1);
      rchk(`ADCMP_OFS_ISTS, 32'h0);
      wr(`ADCMP_OFS_CTRL, 32'h0000_0041);
      ev(5'd0, 16'h0, 1'b0);
      rchk(`ADCMP_OFS_CTRL, {19'h0, 5'd0, 3'b010, 5'h01});
      $display("test irq_off done");
      // unmapped write answers slverr; a low-byte write keeps the upper byte
      wr(8'h20, 32'h0000_FFFF);
      chk(32'(wrsp), 32'h2);
      wstrb <= 4'h1;
      wr(`ADCMP_OFS_ENL, 32'h0000_AA55);
      chk(32'(wrsp), 32'h0);
      wstrb <= 4'hF;
      rchk(`ADCMP_OFS_ENL, 32'h0000_FF55);
      $display("test bus_resp done");
      end_sim();
   end
endmodule
